/* include/tcmc_pkg.sv */
package tcmc_pkg;
  // Byte addresses on the register bus
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_CAPA = 8'h14;
  localparam logic [7:0] ADDR_CAPB = 8'h18;
  localparam logic [7:0] ADDR_CMPC = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;
  localparam logic [7:0] ADDR_ROUTE = 8'hc4;
  // Command bits
  localparam int CMD_EN = 0;
  localparam int CMD_DIS = 1;
  localparam int CMD_TRIG = 2;
  // Mode fields shared by both personalities; the A and B load fields are capture only
  localparam int M_CLKS = 0;
  localparam int M_CLOCK_EDGE_INVERT = 3;
  localparam int M_BURST = 4;
  localparam int M_STOP = 6;
  localparam int M_DIS = 7;
  localparam int M_EDGE = 8;
  localparam int M_WAVE = 15;
  localparam int M_LOADA = 16;
  localparam int M_LOADB = 18;
  // Capture only
  localparam int M_TRIGLINE = 10;
  localparam int M_CTRIG = 14;
  // Waveform only
  localparam int M_EVSRC = 10;
  localparam int M_EVTRIG = 12;
  localparam int M_SHAPE = 13;
  localparam int M_ACTA = 16;
  localparam int M_ACTC = 18;
  localparam int MODE_W = 20;
  localparam logic [MODE_W-1:0] MODE_RESET = 20'h00000;
  // Routing fields
  localparam int R_LINE0 = 0;
  localparam int R_LINE1 = 2;
  localparam int R_LINE2 = 4;
  localparam logic [5:0] ROUTE_RESET = 6'h00;
  // Status bits
  localparam int STAT_CLOCK_ENABLE_CMD = 16;
  localparam int STAT_LINEA = 17;
  localparam int STAT_LINEB = 18;
  // Prescaler taps for internal clocks 1 to 5
  localparam int DIV_W = 10;
  localparam int ICLK_TAP [0:4] = '{0, 2, 4, 6, 9};
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tcmc_apb_type;

  typedef struct packed {
    logic lineAOut;
    logic lineAOe;
    logic lineBOut;
    logic lineBOe;
  } tcmc_pins_type;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } tcmc_dir_type;
endpackage : tcmc_pkg

/* hdl/tcmc_timer.sv */
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Line 0 takes clock pin 0, nothing, channel 1 A or channel 2 A
// - Line 1 takes clock pin 1, nothing, channel 0 A or channel 2 A
// - Line 2 takes clock pin 2, nothing, channel 0 A or channel 1 A
// - Enable command turns clock on unless a disable command or disable event comes in the same cycle
// - Disable command turns the counter clock off
// - Software trigger starts the counter clock; it zeroes the counter except in up/down shapes
// - Source field picks internal clock 1-5 or line 0-2; invert picks edge
// - Gating field ANDs selected clock with line 0, 1 or 2
// - Capture: B load stops the clock when stop bit set
// - Capture: B load disables the clock when disable bit set
// - Capture: trigger edge field picks none, rising, falling, both
// - Capture: trigger comes from line B, or line A when bit set
// - Capture: C match zeroes counter and starts clock when enabled
// - Mode bit picks capture (0) or waveform (1) personality
// - Capture: line A edges load A and B per own fields
// - Waveform: C match stops the clock when stop bit set
// - Waveform: C match disables the clock when disable bit set
// - Waveform: event edge field picks none, rising, falling, both
// - Waveform: event is line B (then input) or line 0-2
// - Waveform: detected event starts clock if enabled, and zeroes counter except in up/down shapes
// - Shape: up or up/down, with or without C match trigger
// - Waveform: A and C matches set, clear or toggle line A
// - Plain up shape counts to the top and wraps to zero
// - In up/down shapes a trigger reverses counting direction
module tcmc_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire tcmc_pkg::tcmc_apb_type apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and neighbouring channels
  input wire logic [2:0] clockPin,
  input wire logic chan1LineA,
  input wire logic chan2LineA,
  input wire logic lineAIn,
  input wire logic lineBIn,
  output tcmc_pkg::tcmc_pins_type pins
);
  import tcmc_pkg::*;

  logic [MODE_W-1:0] mode;
  logic [5:0] route;
  logic [15:0] count, capA, capB, cmpC;
  logic [DIV_W-1:0] div;
  logic clock_enable_cmd, clkRun, lineAReg;
  logic prevClk, prevA, prevTrig, prevEvt;
  tcmc_dir_type dir;
  logic [2:0] extLine;
  logic wave, upDown, lineA, clkLevel, tick, active;
  logic trigSig, evtSig, capTrig, evt, loadA, loadB;
  logic matchA, matchC, autoC, swTrig, extTrig, trigReset;
  logic stopB, stopC, disB, disC;
  logic wr, rdSetup, mapped;
  logic [15:0] top;
  logic [31:0] next_prdata;

  function automatic logic pick(input logic [1:0] s, input logic p,
                                input logic a, input logic b);
    case (s)
      2'b00: pick = p;
      2'b01: pick = 1'b0;
      2'b10: pick = a;
      default: pick = b;
    endcase
  endfunction : pick

  function automatic logic edgeHit(input logic [1:0] s, input logic pv,
                                   input logic cv);
    case (s)
      2'b01: edgeHit = !pv && cv;
      2'b10: edgeHit = pv && !cv;
      2'b11: edgeHit = pv != cv;
      default: edgeHit = 1'b0;
    endcase
  endfunction : edgeHit

  function automatic logic act(input logic [1:0] s, input logic v);
    case (s)
      2'b01: act = 1'b1;
      2'b10: act = 1'b0;
      2'b11: act = !v;
      default: act = v;
    endcase
  endfunction : act

  // Personality and own line A level as the neighbours see it
  assign wave = mode[M_WAVE];
  assign upDown = mode[M_SHAPE];
  assign lineA = wave ? lineAReg : lineAIn;

  // Block clock routing
  assign extLine[0] = pick(route[R_LINE0+:2], clockPin[0], chan1LineA,
                           chan2LineA);
  assign extLine[1] = pick(route[R_LINE1+:2], clockPin[1], lineA,
                           chan2LineA);
  assign extLine[2] = pick(route[R_LINE2+:2], clockPin[2], lineA,
                           chan1LineA);

  // Counting clock: source, gating, edge
  always_comb begin
    logic sel;
    logic gate;
    sel = 1'b0;
    gate = 1'b1;
    case (mode[M_CLKS+:3])
      3'b000: sel = div[ICLK_TAP[0]];
      3'b001: sel = div[ICLK_TAP[1]];
      3'b010: sel = div[ICLK_TAP[2]];
      3'b011: sel = div[ICLK_TAP[3]];
      3'b100: sel = div[ICLK_TAP[4]];
      3'b101: sel = extLine[0];
      3'b110: sel = extLine[1];
      default: sel = extLine[2];
    endcase
    case (mode[M_BURST+:2])
      2'b01: gate = extLine[0];
      2'b10: gate = extLine[1];
      2'b11: gate = extLine[2];
      default: gate = 1'b1;
    endcase
    clkLevel = sel & gate;
  end

  // Edge of the gated level; pins are already synchronous
  assign tick = mode[M_CLOCK_EDGE_INVERT] ? (prevClk && !clkLevel)
                             : (!prevClk && clkLevel);
  assign active = tick && clock_enable_cmd && clkRun;

  // Capture triggers and loads
  assign trigSig = mode[M_TRIGLINE] ? lineAIn : lineBIn;
  assign capTrig = !wave && edgeHit(mode[M_EDGE+:2], prevTrig,
                                    trigSig);
  assign loadA = !wave && edgeHit(mode[M_LOADA+:2], prevA,
                                  lineAIn);
  assign loadB = !wave && edgeHit(mode[M_LOADB+:2], prevA,
                                  lineAIn);

  // Waveform external event
  always_comb begin
    case (mode[M_EVSRC+:2])
      2'b00: evtSig = lineBIn;
      2'b01: evtSig = extLine[0];
      2'b10: evtSig = extLine[1];
      default: evtSig = extLine[2];
    endcase
  end
  assign evt = wave && edgeHit(mode[M_EDGE+:2], prevEvt, evtSig);

  // Compare matches are taken on a counting edge
  assign matchA = wave && active && count == capA;
  assign matchC = active && count == cmpC;
  assign autoC = matchC && (wave ? mode[M_SHAPE+1]
                                 : mode[M_CTRIG]);
  assign extTrig = wave ? (mode[M_EVTRIG] && evt) : capTrig;

  // Bus strobes
  assign wr = apb.psel && apb.penable && apb.pwrite;
  assign rdSetup = apb.psel && !apb.penable && !apb.pwrite;
  assign swTrig = wr && apb.paddr == ADDR_CMD
                  && apb.pwdata[CMD_TRIG];
  // Up/down shapes: any trigger turns the count round without zeroing it
  assign trigReset = (swTrig || extTrig || autoC)
                     && !(wave && upDown);
  assign top = (wave && mode[M_SHAPE+1]) ? cmpC : COUNT_MAX;

  // Clock stop and disable events
  assign stopB = loadB && mode[M_STOP];
  assign disB = loadB && mode[M_DIS];
  assign stopC = wave && matchC && mode[M_STOP];
  assign disC = wave && matchC && mode[M_DIS];

  // Free-running prescaler for the internal clocks
  always_ff @(posedge clock) begin
    if (rst) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // Previous samples for edge detection
  always_ff @(posedge clock) begin
    if (rst) begin
      prevClk <= 1'b0;
      prevA <= 1'b0;
      prevTrig <= 1'b0;
      prevEvt <= 1'b0;
    end else begin
      prevClk <= clkLevel;
      prevA <= lineAIn;
      prevTrig <= trigSig;
      prevEvt <= evtSig;
    end
  end

  // Clock enable: disable command and events beat enable
  always_ff @(posedge clock) begin
    if (rst) begin
      clock_enable_cmd <= 1'b0;
    end else if (wr && apb.paddr == ADDR_CMD && apb.pwdata[CMD_DIS]) begin
      clock_enable_cmd <= 1'b0;
    end else if (disB || disC) begin
      clock_enable_cmd <= 1'b0;
    end else if (wr && apb.paddr == ADDR_CMD && apb.pwdata[CMD_EN]) begin
      clock_enable_cmd <= 1'b1;
    end
  end

  // Run state: a stop beats a trigger in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      clkRun <= 1'b0;
    end else if (stopB || stopC) begin
      clkRun <= 1'b0;
    end else if (swTrig || extTrig || autoC) begin
      clkRun <= 1'b1;
    end
  end

  // Direction, only meaningful in up/down shapes
  always_ff @(posedge clock) begin
    if (rst) begin
      dir <= DIR_UP;
    end else if (!(wave && upDown)) begin
      dir <= DIR_UP;
    end else if (swTrig || extTrig) begin
      dir <= (dir == DIR_UP) ? DIR_DOWN : DIR_UP;
    end else if (active && dir == DIR_UP && count == top) begin
      dir <= DIR_DOWN;
    end else if (active && dir == DIR_DOWN && count == 16'h0000) begin
      dir <= DIR_UP;
    end
  end

  // Counter value
  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 16'h0000;
    end else if (trigReset) begin
      count <= 16'h0000;
    end else if (active && wave && upDown) begin
      if (dir == DIR_UP) begin
        count <= (count == top) ? count - 16'h0001 : count + 16'h0001;
      end else begin
        count <= (count == 16'h0000) ? 16'h0001 : count - 16'h0001;
      end
    end else if (active) begin
      count <= count + 16'h0001;
    end
  end

  // Registers A and B: captured, or written in waveform mode
  always_ff @(posedge clock) begin
    if (rst) begin
      capA <= 16'h0000;
      capB <= 16'h0000;
    end else begin
      if (loadA) begin
        capA <= count;
      end else if (wave && wr && apb.paddr == ADDR_CAPA) begin
        capA <= apb.pwdata[15:0];
      end
      if (loadB) begin
        capB <= count;
      end else if (wave && wr && apb.paddr == ADDR_CAPB) begin
        capB <= apb.pwdata[15:0];
      end
    end
  end

  // Software-owned configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      mode <= MODE_RESET;
      route <= ROUTE_RESET;
      cmpC <= 16'h0000;
    end else if (wr) begin
      if (apb.paddr == ADDR_MODE) begin
        mode <= apb.pwdata[MODE_W-1:0];
      end
      if (apb.paddr == ADDR_ROUTE) begin
        route <= apb.pwdata[5:0];
      end
      if (apb.paddr == ADDR_CMPC) begin
        cmpC <= apb.pwdata[15:0];
      end
    end
  end

  // Line A output; C action applied last so it wins a tie
  always_ff @(posedge clock) begin
    if (rst) begin
      lineAReg <= 1'b0;
    end else if (matchC && wave) begin
      lineAReg <= act(mode[M_ACTC+:2],
                      matchA ? act(mode[M_ACTA+:2], lineAReg)
                             : lineAReg);
    end else if (matchA) begin
      lineAReg <= act(mode[M_ACTA+:2], lineAReg);
    end
  end

  // Pins: line B is released when it serves as the event
  assign pins.lineAOut = lineAReg;
  assign pins.lineAOe = wave;
  assign pins.lineBOut = 1'b0;
  assign pins.lineBOe = wave && mode[M_EVSRC+:2] != 2'b00;

  // Read data latched in the setup cycle
  always_comb begin
    next_prdata = 32'h00000000;
    mapped = 1'b1;
    case (apb.paddr)
      ADDR_CMD: next_prdata = 32'h00000000;
      ADDR_MODE: next_prdata[MODE_W-1:0] = mode;
      ADDR_COUNT: next_prdata[15:0] = count;
      ADDR_CAPA: next_prdata[15:0] = capA;
      ADDR_CAPB: next_prdata[15:0] = capB;
      ADDR_CMPC: next_prdata[15:0] = cmpC;
      ADDR_STAT: begin
        next_prdata[STAT_CLOCK_ENABLE_CMD] = clock_enable_cmd;
        next_prdata[STAT_LINEA] = lineA;
        next_prdata[STAT_LINEB] = lineBIn;
      end
      ADDR_ROUTE: next_prdata[5:0] = route;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rdSetup) begin
      prdata <= next_prdata;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = apb.psel && apb.penable && !mapped;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_route_line0: assert property (
    route[R_LINE0+:2] == 2'b10 |-> extLine[0] == chan1LineA)
    else $error("line 0 not routed from channel 1");
  a_enable_cmd: assert property (
    wr && apb.paddr == ADDR_CMD && apb.pwdata[2:0] == 3'b001
    |=> clock_enable_cmd)
    else $error("enable command ignored");
  a_disable_cmd: assert property (
    wr && apb.paddr == ADDR_CMD && apb.pwdata[CMD_DIS] |=> !clock_enable_cmd)
    else $error("disable command ignored");
  a_soft_trigger: assert property (
    swTrig && !stopB && !stopC && !(wave && upDown)
    |=> count == 16'h0000 && clkRun)
    else $error("software trigger did not restart counter");
  a_stop_b_load: assert property (
    !wave && mode[M_STOP] && loadB |=> !clkRun)
    else $error("B load did not stop clock");
  a_disable_b_load: assert property (
    !wave && mode[M_DIS] && loadB |=> !clock_enable_cmd)
    else $error("B load did not disable clock");
  a_stop_c_match: assert property (
    wave && mode[M_STOP] && active && count == cmpC |=> !clkRun)
    else $error("C match did not stop clock");
  a_disable_c_match: assert property (
    wave && mode[M_DIS] && active && count == cmpC |=> !clock_enable_cmd)
    else $error("C match did not disable clock");
  a_line_b_input: assert property (
    wave && mode[M_EVSRC+:2] == 2'b00 |-> !pins.lineBOe)
    else $error("line B driven while it is the event");
  a_line_a_set: assert property (
    matchA && mode[M_ACTA+:2] == 2'b01 && !matchC |=> pins.lineAOut)
    else $error("A match did not set line A");
  a_up_wrap: assert property (
    wave && mode[M_SHAPE+:2] == 2'b00 && active && count == COUNT_MAX
    && !trigReset |=> count == 16'h0000)
    else $error("up count did not wrap");
  a_updown_flip: assert property (
    wave && upDown && (swTrig || extTrig) |=> dir != $past(dir))
    else $error("trigger did not reverse direction");
  a_updown_start: assert property (
    wave && upDown && swTrig && !stopB && !stopC |=> clkRun)
    else $error("up/down trigger did not start clock");
endmodule : tcmc_timer

/* verification/tcmc_far_side.sv */
`timescale 1ns/1ps
// Far side: clock pins, neighbour channels and the two io wires
module tcmc_far_side (
  // Levels commanded by the bench
  input wire logic [6:0] lvl,
  // Channel pins
  input wire tcmc_pkg::tcmc_pins_type pins,
  output logic [2:0] clockPin,
  output logic chan1LineA,
  output logic chan2LineA,
  output logic lineAIn,
  output logic lineBIn
);
  import tcmc_pkg::*;
  // Pins and neighbour lines follow the bench levels
  assign clockPin = lvl[2:0];
  assign chan1LineA = lvl[3];
  assign chan2LineA = lvl[4];
  // Wire level: the channel wins while it drives, else the far side
  assign lineAIn = pins.lineAOe ? pins.lineAOut : lvl[5];
  assign lineBIn = pins.lineBOe ? pins.lineBOut : lvl[6];
endmodule : tcmc_far_side

/* verification/tb_top.sv */
`timescale 1ns/1ps
// Channel bench: register table, routing rows, then hand cases
module tb_top;
  import tcmc_pkg::*;
  typedef struct {
    logic [31:0] route;
    logic [31:0] mode;
    logic [31:0] cval;
    int src;
    logic [6:0] hold;
    logic [31:0] grow;
    logic en;
  } tcmc_row_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tcmc_apb_type apb = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tcmc_pins_type pins;
  logic [2:0] clockPin;
  logic chan1LineA;
  logic chan2LineA;
  logic lineAIn;
  logic lineBIn;
  logic [6:0] lvl = 7'h00;
  logic [31:0] rd;
  logic [31:0] c1;
  logic err;
  int errors = 0;
  int nCompared = 0;
  logic [2:0] cmds [4] = '{3'h3, 3'h1, 3'h0, 3'h2};
  logic [3:0] ens = 4'b0110;
  logic [1:0] acts [5] = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h2};
  logic [4:0] lvlA = 5'b01011;
  // Route, mode, C, pulsed source, held levels, growth, enabled
  tcmc_row_type rows [16] = '{
    '{32'h00, 32'h5, 32'h0, 0, 7'h0, 32'h2, 1'b1},
    '{32'h01, 32'h5, 32'h0, 0, 7'h0, 32'h0, 1'b1},
    '{32'h02, 32'h5, 32'h0, 3, 7'h0, 32'h2, 1'b1},
    '{32'h03, 32'h5, 32'h0, 4, 7'h0, 32'h2, 1'b1},
    '{32'h00, 32'h6, 32'h0, 1, 7'h0, 32'h2, 1'b1},
    '{32'h04, 32'h6, 32'h0, 1, 7'h0, 32'h0, 1'b1},
    '{32'h08, 32'h6, 32'h0, 5, 7'h0, 32'h2, 1'b1},
    '{32'h0c, 32'h6, 32'h0, 4, 7'h0, 32'h2, 1'b1},
    '{32'h00, 32'h7, 32'h0, 2, 7'h0, 32'h2, 1'b1},
    '{32'h20, 32'h7, 32'h0, 5, 7'h0, 32'h2, 1'b1},
    '{32'h30, 32'h7, 32'h0, 3, 7'h0, 32'h2, 1'b1},
    '{32'h00, 32'hd, 32'h0, 0, 7'h0, 32'h2, 1'b1},
    '{32'h00, 32'h25, 32'h0, 0, 7'h0, 32'h0, 1'b1},
    '{32'h00, 32'h25, 32'h0, 0, 7'h2, 32'h2, 1'b1},
    '{32'h00, 32'h8045, 32'h2, 0, 7'h0, 32'h0, 1'b1},
    '{32'h00, 32'h8085, 32'h2, 0, 7'h0, 32'h0, 1'b0}
  };

  tcmc_timer i_tcmc_timer (
    .clock(clock), .rst(rst), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .clockPin(clockPin),
    .chan1LineA(chan1LineA), .chan2LineA(chan2LineA),
    .lineAIn(lineAIn), .lineBIn(lineBIn), .pins(pins)
  );
  tcmc_far_side i_tcmc_far_side (
    .lvl(lvl), .pins(pins), .clockPin(clockPin),
    .chan1LineA(chan1LineA), .chan2LineA(chan2LineA),
    .lineAIn(lineAIn), .lineBIn(lineBIn)
  );

  // 100 ns system clock
  initial begin
    forever #50 clock = ~clock;
  end

  // One transfer; idle edge after it so the next setup is clean
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    apb.penable <= 1'b1;
    @(posedge clock);
    // Wait states until the slave answers; the watchdog ends this only if it never does
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    apb <= '0;
    @(posedge clock);
  endtask : xfer

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk($sformatf("register %h", a), exp, rd);
  endtask : rdchk

  // Pulses wide enough for the input sampling to see both edges
  task automatic pulse(input int s, input int n);
    repeat (n) begin
      lvl[s] <= 1'b1;
      repeat (2) @(posedge clock);
      lvl[s] <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask : pulse

  task automatic print_verdict;
    if (errors == 0 && nCompared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the roughly 1100 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdchk(ADDR_MODE, 32'h0);
    rdchk(ADDR_ROUTE, 32'h0);
    rdchk(ADDR_STAT, 32'h0);
    xfer(1'b1, ADDR_MODE, 32'hffffffff);
    rdchk(ADDR_MODE, 32'h000fffff);
    xfer(1'b1, ADDR_ROUTE, 32'hffffffff);
    rdchk(ADDR_ROUTE, 32'h0000003f);
    rdchk(ADDR_CMD, 32'h0);
    rdchk(8'h08, 32'h0);
    chk("slave error", 32'h1, {31'h0, err});
    chk("ready", 32'h1, {31'h0, pready});
    xfer(1'b1, ADDR_MODE, 32'h0);
    xfer(1'b1, ADDR_ROUTE, 32'h0);
    // Commands alone and together
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, ADDR_CMD, {29'h0, cmds[i]});
      xfer(1'b0, ADDR_STAT, 32'h0);
      chk("clock enabled", {31'h0, ens[i]},
          {31'h0, rd[STAT_CLOCK_ENABLE_CMD]});
    end
    foreach (rows[i]) begin
      lvl <= rows[i].hold;
      xfer(1'b1, ADDR_ROUTE, rows[i].route);
      xfer(1'b1, ADDR_MODE, rows[i].mode);
      xfer(1'b1, ADDR_CMPC, rows[i].cval);
      xfer(1'b1, ADDR_CMD, 32'h5);
      pulse(rows[i].src, 3);
      xfer(1'b0, ADDR_COUNT, 32'h0);
      c1 = rd;
      pulse(rows[i].src, 2);
      xfer(1'b0, ADDR_COUNT, 32'h0);
      chk("count growth", rows[i].grow, rd - c1);
      xfer(1'b0, ADDR_STAT, 32'h0);
      chk("row enable", {31'h0, rows[i].en},
          {31'h0, rd[STAT_CLOCK_ENABLE_CMD]});
    end
    // Software trigger zeroes a running count
    xfer(1'b1, ADDR_MODE, 32'h5);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 3);
    xfer(1'b1, ADDR_CMD, 32'h4);
    rdchk(ADDR_COUNT, 32'h0);
    // Capture: A on rising, B on falling, B load stops the count
    xfer(1'b1, ADDR_MODE, 32'h90045);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 3);
    lvl[5] <= 1'b1;
    @(posedge clock);
    pulse(0, 1);
    lvl[5] <= 1'b0;
    @(posedge clock);
    pulse(0, 2);
    rdchk(ADDR_CAPA, 32'h3);
    rdchk(ADDR_CAPB, 32'h4);
    rdchk(ADDR_COUNT, 32'h4);
    // Capture trigger: rising on line B, then falling on line A
    xfer(1'b1, ADDR_MODE, 32'h105);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 2);
    lvl[6] <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk(ADDR_COUNT, 32'h0);
    xfer(1'b1, ADDR_MODE, 32'h605);
    pulse(0, 2);
    lvl[5] <= 1'b1;
    repeat (3) @(posedge clock);
    rdchk(ADDR_COUNT, 32'h2);
    lvl[5] <= 1'b0;
    repeat (3) @(posedge clock);
    rdchk(ADDR_COUNT, 32'h0);
    // Waveform: line A actions on an A match
    xfer(1'b1, ADDR_MODE, 32'h8005);
    xfer(1'b1, ADDR_CAPA, 32'h2);
    xfer(1'b1, ADDR_CMPC, 32'h100);
    chk("line A enable", 32'h1, {31'h0, pins.lineAOe});
    chk("line B enable", 32'h0, {31'h0, pins.lineBOe});
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, ADDR_MODE, 32'h8005 | {14'h0, acts[i], 16'h0});
      xfer(1'b1, ADDR_CMD, 32'h5);
      pulse(0, 3);
      chk("line A", {31'h0, lvlA[i]}, {31'h0, pins.lineAOut});
    end
    xfer(1'b1, ADDR_MODE, 32'h8405);
    chk("line B enable", 32'h1, {31'h0, pins.lineBOe});
    chk("line B out", 32'h0, {31'h0, pins.lineBOut});
    // Up shape with C trigger wraps after C
    xfer(1'b1, ADDR_MODE, 32'hc005);
    xfer(1'b1, ADDR_CMPC, 32'h3);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 5);
    rdchk(ADDR_COUNT, 32'h1);
    // Up/down: a trigger turns the count round, no zeroing
    xfer(1'b1, ADDR_MODE, 32'ha005);
    pulse(0, 5);
    xfer(1'b1, ADDR_CMD, 32'h4);
    pulse(0, 2);
    rdchk(ADDR_COUNT, 32'h4);
    xfer(1'b1, ADDR_CMD, 32'h4);
    pulse(0, 1);
    rdchk(ADDR_COUNT, 32'h5);
    // Waveform event on line 1, rising edge, restarts the count
    xfer(1'b1, ADDR_MODE, 32'h9905);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 3);
    pulse(1, 1);
    rdchk(ADDR_COUNT, 32'h0);
    // Capture: B load on rising line A disables the clock
    xfer(1'b1, ADDR_MODE, 32'h40085);
    xfer(1'b1, ADDR_CMD, 32'h5);
    lvl[5] <= 1'b1;
    repeat (2) @(posedge clock);
    xfer(1'b0, ADDR_STAT, 32'h0);
    chk("clock after B load", 32'h0, {31'h0, rd[STAT_CLOCK_ENABLE_CMD]});
    lvl[5] <= 1'b0;
    // Capture: C match restarts the count when enabled
    xfer(1'b1, ADDR_MODE, 32'h4005);
    xfer(1'b1, ADDR_CMPC, 32'h2);
    xfer(1'b1, ADDR_CMD, 32'h5);
    pulse(0, 4);
    rdchk(ADDR_COUNT, 32'h1);
    // Reset in mid-run returns everything to idle
    lvl <= 7'h00;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdchk(ADDR_MODE, 32'h0);
    rdchk(ADDR_COUNT, 32'h0);
    rdchk(ADDR_STAT, 32'h0);
    print_verdict();
  end
endmodule : tb_top
